//--- ulf_line_format.sv
// uart line format, trigger level and modem output control
// Summary of operation
// - transmit request when count falls below level, or empty if never refilled above
// - one trigger table serves receive and transmit together
// - receive request when receive count reaches level; default select gives one
// - feature control bits 5:4 choose table A, B, C or D
// - table A: receive 1,4,8,14; transmit fixed at 1
// - table B: receive 8,16,24,28; transmit 16,8,24,30
// - table C: transmit 8,16,32,56; receive 8,16,56,60
// - table D: levels from trigger register, direction bit picks receive or transmit
// - word length field sets data bits, code 00 gives five
// - stop bit: one; when set 1.5 for five bits, else two
// - parity enable adds parity on transmit and checks on receive
// - parity type zero odd, one even, shared by both directions
// - forced parity: mark when type zero, space when type one
// - break bit holds serial output low until cleared
// - divisor access bit maps data locations onto divisor latches
// - terminal ready bit drives its active low pin, default high
// - request to send bit drives its active low pin, default high
// - automatic request to send lets flow control drive that pin
`timescale 1ns/1ns
`default_nettype none
`include "ulf_cfg.svh"

module ulf_line_format
  import ulf_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  input  wire logic [`ULF_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [7:0]             reg_rdata,
  input  wire logic [6:0]             tx_count,
  input  wire logic [6:0]             rx_count,
  input  wire logic [7:0]             rx_data,
  input  wire logic                   tx_serial,
  output logic                        txd,
  output logic                        dtr_n,
  output logic                        rts_n,
  output logic                        tx_irq,
  output logic                        rx_irq,
  output logic                        data_wr,
  output logic                        data_rd,
  output logic      [7:0]             data_wdata,
  output logic      [15:0]            divisor,
  output ulf_format_t                 line_format,
  output logic                        queue_en,
  output logic      [7:0]             rx_level,
  output logic      [7:0]             tx_level
);

  ulf_state_t st_reg;
  ulf_state_t st_next;
  ulf_table_t table_sel;
  logic       div_access;
  logic [7:0] rx_lvl;
  logic [7:0] tx_lvl;

  // receive threshold of the selected table and code
  function automatic logic [7:0] rx_lookup(input ulf_table_t t, input logic [1:0] s,
                                          input logic [7:0] programmable_trigger_register);
    logic [7:0] v;
    v = 8'h01;
    unique case (t)
      ULF_TABLE_A: begin
        unique case (s)
          2'b00: begin
            v = 8'h01;
          end
          2'b01: begin
            v = 8'h04;
          end
          2'b10: begin
            v = 8'h08;
          end
          2'b11: begin
            v = 8'h0e;
          end
        endcase
      end
      ULF_TABLE_B: begin
        unique case (s)
          2'b00: begin
            v = 8'h08;
          end
          2'b01: begin
            v = 8'h10;
          end
          2'b10: begin
            v = 8'h18;
          end
          2'b11: begin
            v = 8'h1c;
          end
        endcase
      end
      ULF_TABLE_C: begin
        unique case (s)
          2'b00: begin
            v = 8'h08;
          end
          2'b01: begin
            v = 8'h10;
          end
          2'b10: begin
            v = 8'h38;
          end
          2'b11: begin
            v = 8'h3c;
          end
        endcase
      end
      ULF_TABLE_D: begin
        v = programmable_trigger_register;
      end
    endcase
    return v;
  endfunction

  // transmit threshold of the selected table and code
  function automatic logic [7:0] tx_lookup(input ulf_table_t t, input logic [1:0] s,
                                          input logic [7:0] programmable_trigger_register);
    logic [7:0] v;
    v = 8'h01;
    unique case (t)
      ULF_TABLE_A: begin
        v = 8'h01;
      end
      ULF_TABLE_B: begin
        unique case (s)
          2'b00: begin
            v = 8'h10;
          end
          2'b01: begin
            v = 8'h08;
          end
          2'b10: begin
            v = 8'h18;
          end
          2'b11: begin
            v = 8'h1e;
          end
        endcase
      end
      ULF_TABLE_C: begin
        unique case (s)
          2'b00: begin
            v = 8'h08;
          end
          2'b01: begin
            v = 8'h10;
          end
          2'b10: begin
            v = 8'h20;
          end
          2'b11: begin
            v = 8'h38;
          end
        endcase
      end
      ULF_TABLE_D: begin
        v = programmable_trigger_register;
      end
    endcase
    return v;
  endfunction

  // one table select feeds both directions
  assign table_sel  = ulf_table_t'(st_reg.feature[`ULF_FC_TABLE_LO +: 2]);
  assign div_access = st_reg.line[`ULF_LF_DIV_ACCESS];
  assign rx_lvl     = rx_lookup(table_sel, st_reg.rx_sel, st_reg.rx_trg);
  assign tx_lvl     = tx_lookup(table_sel, st_reg.tx_sel, st_reg.tx_trg);

  always_comb begin
    st_next         = st_reg;
    st_next.data_wr = 1'b0;
    st_next.data_rd = 1'b0;
    st_next.rdata   = 8'h00;

    // register write decode
    if (reg_wr) begin
      unique case (reg_addr)
        `ULF_OFF_DATA: begin
          if (div_access) begin
            st_next.div_low = reg_wdata;
          end else begin
            st_next.data_wr    = 1'b1;
            st_next.data_wdata = reg_wdata;
          end
        end
        `ULF_OFF_DIV_HIGH: begin
          if (div_access) begin
            st_next.div_high = reg_wdata;
          end
        end
        `ULF_OFF_QUEUE: begin
          st_next.queue_en = reg_wdata[`ULF_QC_ENABLE];
          if (reg_wdata[`ULF_QC_ENABLE]) begin
            st_next.rx_sel = reg_wdata[`ULF_QC_RX_SEL_LO +: 2];
            if (st_reg.enhanced[`ULF_EF_ENHANCED]) begin
              st_next.tx_sel = reg_wdata[`ULF_QC_TX_SEL_LO +: 2];
            end
          end
        end
        `ULF_OFF_LINE: begin
          st_next.line = reg_wdata;
        end
        `ULF_OFF_MODEM: begin
          st_next.modem = reg_wdata;
        end
        `ULF_OFF_FEATURE: begin
          st_next.feature = reg_wdata;
        end
        `ULF_OFF_ENHANCED: begin
          st_next.enhanced = reg_wdata;
        end
        `ULF_OFF_TRIGGER: begin
          if (st_reg.feature[`ULF_FC_TRG_DIR]) begin
            st_next.tx_trg = reg_wdata;
          end else begin
            st_next.rx_trg = reg_wdata;
          end
        end
        default: ;
      endcase
    end

    // register read decode, answered one cycle later
    if (reg_rd) begin
      unique case (reg_addr)
        `ULF_OFF_DATA: begin
          if (div_access) begin
            st_next.rdata = st_reg.div_low;
          end else begin
            st_next.rdata   = rx_data;
            st_next.data_rd = 1'b1;
          end
        end
        `ULF_OFF_DIV_HIGH: begin
          if (div_access) begin
            st_next.rdata = st_reg.div_high;
          end else begin
            st_next.rdata = 8'h00;
          end
        end
        `ULF_OFF_LINE: begin
          st_next.rdata = st_reg.line;
        end
        `ULF_OFF_MODEM: begin
          st_next.rdata = st_reg.modem;
        end
        `ULF_OFF_FEATURE: begin
          st_next.rdata = st_reg.feature;
        end
        `ULF_OFF_ENHANCED: begin
          st_next.rdata = st_reg.enhanced;
        end
        `ULF_OFF_RX_LEVEL: begin
          st_next.rdata = rx_lvl;
        end
        `ULF_OFF_TX_LEVEL: begin
          st_next.rdata = tx_lvl;
        end
        default: begin
          st_next.rdata = 8'h00;
        end
      endcase
    end

    // transmit request tracking
    if ({1'b0, tx_count} > tx_lvl) begin
      st_next.tx_filled = 1'b1;
    end else if (tx_count == 7'h00) begin
      st_next.tx_filled = 1'b0;
    end
    // empty always requests; below level only after a refill above it
    if (tx_count == 7'h00) begin
      st_next.tx_irq = 1'b1;
    end else if (st_reg.tx_filled && ({1'b0, tx_count} < tx_lvl)) begin
      st_next.tx_irq = 1'b1;
    end else begin
      st_next.tx_irq = 1'b0;
    end
    if ({1'b0, rx_count} >= rx_lvl) begin
      st_next.rx_irq = 1'b1;
    end else begin
      st_next.rx_irq = 1'b0;
    end

    // pin outputs, one cycle behind their control bits
    if (st_reg.line[`ULF_LF_BREAK]) begin
      st_next.txd = 1'b0;
    end else begin
      st_next.txd = tx_serial;
    end
    st_next.dtr_n = ~st_reg.modem[`ULF_MO_DTR];
    if (st_reg.enhanced[`ULF_EF_AUTO_RTS]) begin
      st_next.rts_n = ({1'b0, rx_count} >= rx_lvl);
    end else begin
      st_next.rts_n = ~st_reg.modem[`ULF_MO_RTS];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg            <= '0;
      st_reg.line       <= `ULF_RST_REG8;
      st_reg.modem      <= `ULF_RST_REG8;
      st_reg.feature    <= `ULF_RST_REG8;
      st_reg.enhanced   <= `ULF_RST_REG8;
      st_reg.rx_trg     <= `ULF_RST_TRG;
      st_reg.tx_trg     <= `ULF_RST_TRG;
      st_reg.div_low    <= `ULF_RST_DIV;
      st_reg.div_high   <= `ULF_RST_DIV;
      st_reg.txd        <= 1'b1;
      st_reg.dtr_n      <= 1'b1;
      st_reg.rts_n      <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // character format decode
  always_comb begin
    unique case (st_reg.line[`ULF_LF_WLEN_LO +: 2])
      2'b00: begin
        line_format.data_bits = 4'h5;
      end
      2'b01: begin
        line_format.data_bits = 4'h6;
      end
      2'b10: begin
        line_format.data_bits = 4'h7;
      end
      2'b11: begin
        line_format.data_bits = 4'h8;
      end
    endcase
    if (!st_reg.line[`ULF_LF_STOP]) begin
      line_format.stop_half_bits = 3'h2;
    end else if (st_reg.line[`ULF_LF_WLEN_LO +: 2] == 2'b00) begin
      line_format.stop_half_bits = 3'h3;
    end else begin
      line_format.stop_half_bits = 3'h4;
    end
    line_format.parity_en        = st_reg.line[`ULF_LF_PAR_EN];
    line_format.parity_even      = st_reg.line[`ULF_LF_PAR_EVEN];
    line_format.parity_forced    = st_reg.line[`ULF_LF_PAR_FORCE];
    line_format.parity_force_val = ~st_reg.line[`ULF_LF_PAR_EVEN];
  end

  // all outputs except the levels and the line_format decode come straight from flip-flops
  assign reg_rdata  = st_reg.rdata;
  assign txd        = st_reg.txd;
  assign dtr_n      = st_reg.dtr_n;
  assign rts_n      = st_reg.rts_n;
  assign tx_irq     = st_reg.tx_irq;
  assign rx_irq     = st_reg.rx_irq;
  assign data_wr    = st_reg.data_wr;
  assign data_rd    = st_reg.data_rd;
  assign data_wdata = st_reg.data_wdata;
  assign divisor    = {st_reg.div_high, st_reg.div_low};
  assign queue_en   = st_reg.queue_en;
  assign rx_level   = rx_lvl;
  assign tx_level   = tx_lvl;

endmodule
`default_nettype wire

//--- ulf_cfg.svh
// register offsets, field positions and reset values of the line format block
`ifndef ULF_CFG_SVH
`define ULF_CFG_SVH

`define ULF_ADDR_W        4
`define ULF_OFF_DATA      4'h0
`define ULF_OFF_DIV_HIGH  4'h1
`define ULF_OFF_QUEUE     4'h2
`define ULF_OFF_LINE      4'h3
`define ULF_OFF_MODEM     4'h4
`define ULF_OFF_FEATURE   4'h8
`define ULF_OFF_ENHANCED  4'h9
`define ULF_OFF_TRIGGER   4'ha
`define ULF_OFF_RX_LEVEL  4'hb
`define ULF_OFF_TX_LEVEL  4'hc

`define ULF_QC_ENABLE     0
`define ULF_QC_TX_SEL_LO  4
`define ULF_QC_RX_SEL_LO  6
`define ULF_LF_WLEN_LO    0
`define ULF_LF_STOP       2
`define ULF_LF_PAR_EN     3
`define ULF_LF_PAR_EVEN   4
`define ULF_LF_PAR_FORCE  5
`define ULF_LF_BREAK      6
`define ULF_LF_DIV_ACCESS 7
`define ULF_MO_DTR        0
`define ULF_MO_RTS        1
`define ULF_FC_TABLE_LO   4
`define ULF_FC_TRG_DIR    7
`define ULF_EF_ENHANCED   4
`define ULF_EF_AUTO_RTS   6

`define ULF_RST_REG8      8'h00
`define ULF_RST_TRG       8'h01
`define ULF_RST_DIV       8'h00

`endif

//--- ulf_pkg.sv
// types of the line format and trigger block
package ulf_pkg;

  typedef enum logic [1:0] {
    ULF_TABLE_A = 2'b00,
    ULF_TABLE_B = 2'b01,
    ULF_TABLE_C = 2'b10,
    ULF_TABLE_D = 2'b11
  } ulf_table_t;

  typedef struct packed {
    logic       queue_en;
    logic [1:0] rx_sel;
    logic [1:0] tx_sel;
    logic [7:0] line;
    logic [7:0] modem;
    logic [7:0] feature;
    logic [7:0] enhanced;
    logic [7:0] rx_trg;
    logic [7:0] tx_trg;
    logic [7:0] div_low;
    logic [7:0] div_high;
    logic [7:0] rdata;
    logic       data_wr;
    logic       data_rd;
    logic [7:0] data_wdata;
    logic       txd;
    logic       dtr_n;
    logic       rts_n;
    logic       tx_filled;
    logic       tx_irq;
    logic       rx_irq;
  } ulf_state_t;

  typedef struct packed {
    logic [3:0] data_bits;
    logic [2:0] stop_half_bits;
    logic       parity_en;
    logic       parity_even;
    logic       parity_forced;
    logic       parity_force_val;
  } ulf_format_t;

endpackage

//--- ulf_line_monitor.sv
// port assertions of the line format block
`timescale 1ns/1ns
`default_nettype none
`include "ulf_cfg.svh"
module ulf_line_monitor
  import ulf_pkg::*;
(
  input wire logic                   sys_clk,
  input wire logic                   rst_n,
  input wire logic [`ULF_ADDR_W-1:0] reg_addr,
  input wire logic [7:0]             reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [7:0]             reg_rdata,
  input wire logic [6:0]             tx_count,
  input wire logic [6:0]             rx_count,
  input wire logic                   txd,
  input wire logic                   dtr_n,
  input wire logic                   tx_irq,
  input wire logic                   rx_irq,
  input wire logic                   data_wr,
  input wire logic                   data_rd,
  input wire logic [7:0]             data_wdata,
  input wire ulf_format_t            line_format,
  input wire logic [7:0]             rx_level
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  break_low_a: assert property (reg_wr && reg_addr == 4'h3 && reg_wdata[6] |-> ##2 !txd)
    else $error("break did not hold the serial output low");
  dtr_pin_a: assert property (reg_wr && reg_addr == 4'h4 |-> ##2 dtr_n == !$past(reg_wdata[0], 2))
    else $error("terminal ready pin does not follow its bit");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  data_wr_a: assert property (data_wr |-> $past(reg_wr) && $past(reg_addr) == 4'h0)
    else $error("data write pulse without a data write");
  data_rd_a: assert property (data_rd |-> $past(reg_rd) && $past(reg_addr) == 4'h0)
    else $error("data read pulse without a data read");
  rx_request_a: assert property ($past(rst_n) |-> rx_irq == $past({1'b0, rx_count} >= rx_level))
    else $error("receive request does not match level");
  tx_empty_a: assert property ($past(rst_n) && $past(tx_count) == 7'h00 |-> tx_irq)
    else $error("transmit request missing on empty queue");
  word_len_a: assert property (line_format.data_bits >= 4'h5 && line_format.data_bits <= 4'h8)
    else $error("data bit count out of range");
  stop_len_a: assert property (line_format.stop_half_bits == 3'h2 || line_format.stop_half_bits ==
    ((line_format.data_bits == 4'h5) ? 3'h3 : 3'h4)) else $error("stop length wrong");
  force_val_a: assert property (line_format.parity_forced |->
    line_format.parity_force_val == !line_format.parity_even) else $error("forced parity wrong");
endmodule
bind ulf_line_format ulf_line_monitor u_mon (.*);
`default_nettype wire

//--- ulf_far_model.sv
// far side model: serial stream source and queue fill counts
`timescale 1ns/1ns
`default_nettype none
module ulf_far_model (
  input  wire logic       sys_clk,
  input  wire logic [6:0] tx_want,
  input  wire logic [6:0] rx_want,
  output logic      [6:0] tx_count,
  output logic      [6:0] rx_count,
  output logic            tx_serial
);
  initial begin
    tx_count = 7'h00;
    rx_count = 7'h00;
    tx_serial = 1'b0;
  end
  always @(posedge sys_clk) begin
    tx_count <= tx_want;
    rx_count <= rx_want;
    tx_serial <= ~tx_serial;
  end
endmodule
`default_nettype wire

//--- tb_ulf_line_format.sv
// self-checking testbench of the line format block
`timescale 1ns/1ns
`default_nettype none
module tb_ulf_line_format
  import ulf_pkg::*;
;
  logic sys_clk, rst_n, reg_wr, reg_rd, tx_serial, txd, dtr_n, rts_n, tx_irq, rx_irq;
  logic data_wr, data_rd, queue_en;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rx_data, data_wdata, rx_level, tx_level, d;
  logic [6:0] tx_count, rx_count, tx_want, rx_want;
  logic [15:0] divisor;
  ulf_format_t line_format, fe;
  int n_mismatch, n_checks;
  ulf_line_format u_dut (.*);
  ulf_far_model u_far (.*);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic t_tables;
    logic [7:0] rxe [3][4];
    logic [7:0] txe [3][4];
    rxe = '{'{8'h01, 8'h04, 8'h08, 8'h0e}, '{8'h08, 8'h10, 8'h18, 8'h1c},
            '{8'h08, 8'h10, 8'h38, 8'h3c}};
    txe = '{'{8'h01, 8'h01, 8'h01, 8'h01}, '{8'h10, 8'h08, 8'h18, 8'h1e},
            '{8'h08, 8'h10, 8'h20, 8'h38}};
    chk("rx reset", rx_level, 16'h0001);
    for (int t = 0; t < 3; t++) begin
      for (int c = 0; c < 4; c++) begin
        wr(4'h8, 8'(t << 4));
        wr(4'h9, 8'h10);
        wr(4'h2, {2'(c), 2'(3 - c), 4'h1});
        settle(1);
        chk("rx level", rx_level, rxe[t][c]);
        chk("tx level", tx_level, txe[t][3 - c]);
      end
    end
    wr(4'h9, 8'h00);
    wr(4'h2, 8'h31);
    wr(4'h2, 8'hc0);
    settle(1);
    chk("tx locked", tx_level, 16'h0008);
    chk("rx kept", rx_level, 16'h0008);
    chk("queue en", queue_en, 16'h0000);
    wr(4'h8, 8'h30);
    wr(4'ha, 8'h16);
    wr(4'h8, 8'hb0);
    wr(4'ha, 8'h05);
    settle(1);
    chk("rx trg", rx_level, 16'h0016);
    chk("tx trg", tx_level, 16'h0005);
  endtask
  task automatic t_format;
    for (int v = 0; v < 64; v++) begin
      wr(4'h3, 8'(v));
      #1;
      fe.data_bits = 4'h5 + 4'(v % 4);
      fe.stop_half_bits = v[2] ? ((v % 4 == 0) ? 3'h3 : 3'h4) : 3'h2;
      fe.parity_en = v[3];
      fe.parity_even = v[4];
      fe.parity_forced = v[5];
      fe.parity_force_val = !v[4];
      chk("format", line_format, fe);
    end
    rd(4'h3);
    chk("line rd", d, 16'h003f);
    wr(4'h3, 8'h40);
    settle(2);
    chk("break", txd, 16'h0000);
    settle(1);
    chk("break", txd, 16'h0000);
    wr(4'h3, 8'h00);
    settle(2);
    d[0] = tx_serial;
    settle(1);
    chk("txd", txd, d[0]);
  endtask
  task automatic t_div;
    wr(4'h3, 8'h80);
    wr(4'h0, 8'h34);
    wr(4'h1, 8'h12);
    settle(1);
    chk("divisor", divisor, 16'h1234);
    rd(4'h1);
    chk("div rd", d, 16'h0012);
    wr(4'h3, 8'h00);
    rx_data <= 8'h5a;
    rd(4'h0);
    chk("data rd", d, 16'h005a);
    chk("data rd pulse", data_rd, 16'h0001);
    wr(4'h0, 8'ha5);
    #1;
    chk("data wr pulse", data_wr, 16'h0001);
    settle(1);
    chk("data wr end", data_wr, 16'h0000);
    chk("data wr", data_wdata, 16'h00a5);
    chk("div kept", divisor, 16'h1234);
    rd(4'h1);
    chk("div hid", d, 16'h0000);
    rd(4'hf);
    chk("unmapped", d, 16'h0000);
  endtask
  task automatic t_pins;
    chk("dtr reset", dtr_n, 16'h0001);
    chk("rts reset", rts_n, 16'h0001);
    wr(4'h4, 8'h01);
    settle(2);
    chk("dtr low", dtr_n, 16'h0000);
    chk("rts high", rts_n, 16'h0001);
    wr(4'h8, 8'h10);
    wr(4'h9, 8'h10);
    wr(4'h2, 8'h01);
    wr(4'h4, 8'h02);
    tx_want <= 7'd20;
    settle(3);
    chk("dtr high", dtr_n, 16'h0001);
    chk("rts low", rts_n, 16'h0000);
    chk("tx full", tx_irq, 16'h0000);
    tx_want <= 7'd10;
    settle(3);
    chk("tx below", tx_irq, 16'h0001);
    tx_want <= 7'd0;
    settle(3);
    chk("tx empty", tx_irq, 16'h0001);
    tx_want <= 7'd5;
    rx_want <= 7'd7;
    settle(3);
    chk("tx unfilled", tx_irq, 16'h0000);
    chk("rx under", rx_irq, 16'h0000);
    rx_want <= 7'd8;
    wr(4'h9, 8'h50);
    settle(3);
    chk("rx level", rx_irq, 16'h0001);
    chk("rts flow", rts_n, 16'h0001);
    rx_want <= 7'd3;
    settle(3);
    chk("rts flow", rts_n, 16'h0000);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    {reg_wr, reg_rd, reg_addr, reg_wdata, rx_data, tx_want, rx_want} = '0;
    n_mismatch = 0;
    n_checks = 0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_tables;
    t_pins;
    t_format;
    t_div;
    end_sim;
  end
  initial begin
    #200000;
    n_mismatch++;
    end_sim;
  end
endmodule
`default_nettype wire
